// >>> logic/lp_state_pkg.sv
// lp_state_pkg: command opcodes, state types and interval counts
// shared by the tracker top and its per-bank state machine
package lp_state_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CA_W = 10;
  localparam int TMR_W = 8;
  localparam int MA_W = 8;
  // field positions on the rising and falling halves of ca
  localparam int CA_AB = 4;
  localparam int CA_BA_LO = 7;
  localparam int CA_MA_LO = 4;
  localparam int CA_AP = 0;
  localparam int CA_F_W = 2;
  // opcodes on ca[3:0], ca[2:0] or ca[1:0], rising half
  localparam logic [3:0] OP_MRW = 4'h0;
  localparam logic [3:0] OP_MRR = 4'h8;
  localparam logic [3:0] OP_REF_PB = 4'h4;
  localparam logic [3:0] OP_REF_AB = 4'hC;
  localparam logic [3:0] OP_PRE = 4'hB;
  localparam logic [3:0] OP_BST = 4'h3;
  localparam logic [2:0] OP_WR = 3'h1;
  localparam logic [2:0] OP_RD = 3'h5;
  localparam logic [2:0] OP_NOP = 3'h7;
  localparam logic [2:0] OP_SREF = 3'h4;
  localparam logic [2:0] OP_DPD = 3'h3;
  localparam logic [1:0] OP_ACT = 2'h2;
  localparam logic [MA_W-1:0] RESET_MA = 8'h3F;
  // link-side intervals, counted in ck cycles
  localparam int TRP_CK = 3;
  localparam int TRCD_CK = 3;
  localparam int TRFCPB_CK = 30;
  localparam int TRFCAB_CK = 60;
  localparam int TMRR_CK = 2;
  localparam int TMRW_CK = 5;
  localparam int TXP_CK = 2;
  localparam int TXSR_CK = 70;
  // init interval, timed on mclk
  localparam int MCLK_PERIOD_NS = 20;
  localparam int T_INIT5_NS = 10000;
  localparam int INIT5_CYCLES = (T_INIT5_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  typedef enum logic [3:0] {CMD_NOP, CMD_MRW, CMD_MRR, CMD_REF_PB, CMD_REF_AB, CMD_ACT,
    CMD_WR, CMD_RD, CMD_PRE, CMD_BST, CMD_RSVD} cmd_type;
  typedef enum logic [3:0] {DEV_POWER_ON, DEV_RESETTING, DEV_RES_MRR, DEV_NORMAL, DEV_MR_WRITING,
    DEV_IDLE_MRR, DEV_REF_ALL, DEV_ACT_PD, DEV_IDLE_PD, DEV_RES_PD, DEV_SELF_REF,
    DEV_DEEP_PD} dev_type;
  typedef enum logic [3:0] {B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING, B_RD_AP,
    B_WR_AP, B_PRECHARGING, B_REFRESHING, B_ACT_MRR} bank_type;
endpackage

// >>> logic/sync_3ff.sv
// sync_3ff: three-stage level synchroniser with settle check
// assumes din is a slow level from another clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_3ff (
  input wire logic clk, // destination clock
  input wire logic rst, // sync reset, destination domain
  input wire logic din, // level from the other domain
  output logic dout // settled level
);
  logic ff1, ff2, ff3;

  // plain shift chain; ff1 feeds only ff2
  always_ff @(posedge clk) begin
    ff1 <= din;
    ff2 <= ff1;
    ff3 <= ff2;
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (ff2 == ff3) begin
      dout <= ff3;
    end
  end
endmodule
`default_nettype wire

// >>> logic/bank_fsm.sv
// bank_fsm: state of one bank, stepped by decoded command strobes
// assumes strobes come only when the top allows bank commands
`timescale 1ns/100ps
`default_nettype none
module bank_fsm #(
  parameter int TRP = lp_state_pkg::TRP_CK,
  parameter int TRCD = lp_state_pkg::TRCD_CK,
  parameter int TRFC = lp_state_pkg::TRFCPB_CK,
  parameter int TMRR = lp_state_pkg::TMRR_CK
) (
  input wire logic clk, // link clock
  input wire logic rst, // sync reset, link domain
  input wire logic act, // activate this bank
  input wire logic rd, // read to this bank
  input wire logic wr, // write to this bank
  input wire logic pre, // precharge this bank
  input wire logic bst, // burst terminate aimed here
  input wire logic ref_cmd, // per-bank refresh
  input wire logic mrr, // mode register read, device wide
  input wire logic ap, // auto precharge with rd or wr
  output var lp_state_pkg::bank_type state, // current bank state
  output logic idle // bank fully idle
);
  import lp_state_pkg::*;
  bank_type next_state, burst_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic tmr_done;

  assign tmr_done = tmr == '0;
  assign idle = state == B_IDLE;
  // new burst target; the auto-precharge flavour is timed by tRP
  assign burst_state = rd ? (ap ? B_RD_AP : B_READING) : (ap ? B_WR_AP : B_WRITING);

  // timed states ignore strobes: a bank busy there takes only nop
  always_comb begin
    next_state = state;
    next_tmr = tmr_done ? tmr : tmr - 1'b1;
    case (state)
      B_IDLE: begin
        if (act) begin
          next_state = B_ACTIVATING; // RULE_12
          next_tmr = TMR_W'(TRCD - 1);
        end else if (ref_cmd) begin
          next_state = B_REFRESHING; // RULE_12
          next_tmr = TMR_W'(TRFC - 1);
        end else if (pre) begin
          next_state = B_PRECHARGING; // RULE_14 RULE_23
          next_tmr = TMR_W'(TRP - 1);
        end
      end
      B_ACTIVE: begin
        if (rd || wr) begin
          next_state = burst_state; // RULE_15
          next_tmr = TMR_W'(TRP - 1);
        end else if (mrr) begin
          next_state = B_ACT_MRR; // RULE_15
          next_tmr = TMR_W'(TMRR - 1);
        end else if (pre) begin
          next_state = B_PRECHARGING; // RULE_14
          next_tmr = TMR_W'(TRP - 1);
        end
      end
      B_READING, B_WRITING: begin
        if (rd || wr) begin
          next_state = burst_state; // RULE_16 RULE_17
          next_tmr = TMR_W'(TRP - 1);
        end else if (bst) begin
          next_state = B_ACTIVE; // RULE_18
        end
      end
      B_ACTIVATING, B_ACT_MRR: begin
        if (tmr_done) next_state = B_ACTIVE; // RULE_21 RULE_22
      end
      B_PRECHARGING, B_RD_AP, B_WR_AP, B_REFRESHING: begin
        if (tmr_done) next_state = B_IDLE; // RULE_20 RULE_22
      end
      default: next_state = B_IDLE;
    endcase
  end

  // RULE_25
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= B_IDLE;
      tmr <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
    end
  end

  act_open_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
    state == B_IDLE && act |=> (state == B_ACTIVATING)[*3] ##1 state == B_ACTIVE)
    else $error("activate did not open the row after three cycles");
  pre_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE_20
    (state == B_IDLE || state == B_ACTIVE) && pre && !act && !rd && !wr && !mrr && !ref_cmd
    |=> (state == B_PRECHARGING)[*3] ##1 state == B_IDLE)
    else $error("precharge did not reach idle after three cycles");
  bst_end_a: assert property (@(posedge clk) disable iff (rst) // RULE_18
    (state == B_READING || state == B_WRITING) && bst && !rd && !wr |=> state == B_ACTIVE)
    else $error("burst terminate did not return bank to active");
  burst_go_a: assert property (@(posedge clk) disable iff (rst) // RULE_16
    state inside {B_ACTIVE, B_READING, B_WRITING} && rd && !ap |=> state == B_READING)
    else $error("read did not enter reading");
endmodule
`default_nettype wire

// >>> logic/sdram_bank_power_state_tracker.sv
// sdram_bank_power_state_tracker: power and bank state of the memory
// assumes ck comes from the controller; cke, cs_n, ca are in its domain
// Function
// RULE_01 - cke low at both edges: hold low-power state, ignore cs_n and ca
// RULE_02 - cke rise with nop leaves power down to active or idle
// RULE_03 - leaving resetting power down: idle if init expired, else resetting
// RULE_04 - cke rise with nop in deep power down enters power on
// RULE_05 - cke rise with nop in self refresh returns to idle; then tXSR nops
// RULE_06 - after power down exit controller sends only nop until tXP
// RULE_07 - controller toggles the clock during tXP and tXSR
// RULE_08 - cke fall with cs_n high picks active, idle or resetting power down
// RULE_09 - self refresh or deep power down entry only with all banks idle
// RULE_10 - controller sends no unlisted state and command combination
// RULE_11 - bank commands only with cke high twice and exit interval met
// RULE_12 - idle bank: activate opens row, refresh starts per bank or all
// RULE_13 - idle: mode write, mode read, reset move device; write and reset need idle
// RULE_14 - precharge from idle or active bank enters precharging
// RULE_15 - active bank: read, write, mode read enter their states
// RULE_16 - reading bank: read restarts reading, write enters writing
// RULE_17 - writing bank: write restarts writing, read enters reading
// RULE_18 - burst terminate in reading or writing returns bank to active
// RULE_19 - reset in power on enters resetting; mode read there enters its state
// RULE_20 - bank idle only after precharge plus tRP
// RULE_21 - bank active once row open and tRCD met
// RULE_22 - timed bank states take only nop; end after tRP or tRCD
// RULE_23 - tRP still applies to precharge of an idle bank
// RULE_24 - burst terminate acts on the most recent burst, any bank
// RULE_25 - eight bank state registers plus separate device state
`timescale 1ns/100ps
`default_nettype none
module sdram_bank_power_state_tracker #(
  parameter int INIT5_CYCLES = lp_state_pkg::INIT5_CYCLES,
  parameter int TRP = lp_state_pkg::TRP_CK,
  parameter int TRCD = lp_state_pkg::TRCD_CK,
  parameter int TRFCPB = lp_state_pkg::TRFCPB_CK,
  parameter int TRFCAB = lp_state_pkg::TRFCAB_CK,
  parameter int TMRR = lp_state_pkg::TMRR_CK,
  parameter int TMRW = lp_state_pkg::TMRW_CK,
  parameter int TXP = lp_state_pkg::TXP_CK,
  parameter int TXSR = lp_state_pkg::TXSR_CK
) (
  input wire logic mclk, // system clock, 50 MHz
  input wire logic rst, // sync reset, mclk domain
  input wire logic ck, // link clock from the controller
  input wire logic cke, // clock enable pin
  input wire logic cs_n, // chip select, active low
  input wire logic [lp_state_pkg::CA_W-1:0] ca, // command/address, both edges
  output var lp_state_pkg::dev_type dev_state, // device power state
  output var lp_state_pkg::bank_type bank_state [lp_state_pkg::NUM_BANKS], // per bank
  output logic cmd_open, // bank commands accepted this cycle
  output logic init_done // init interval done, mclk domain
);
  import lp_state_pkg::*;
  localparam int CNT_W = $clog2(INIT5_CYCLES + 1);

  logic rst_ck;
  logic cke_cur, cke_prev, csn_q;
  logic [CA_W-1:0] ca_q;
  logic [CA_F_W-1:0] ca_f;
  cmd_type cmd;
  logic both_high, cke_fall, exit_nop, dev_cmd, is_reset, start_init, all_idle;
  logic [BANK_W-1:0] ba, last_bank;
  logic [MA_W-1:0] ma;
  logic [NUM_BANKS-1:0] act_v, rd_v, wr_v, pre_v, bst_v, ref_v, mrr_v, bank_idle;
  dev_type next_dev;
  logic [TMR_W-1:0] dtmr, next_dtmr, exit_cnt, next_exit;
  logic rst_tog, done_ck, init_exp;
  logic tog_m, tog_seen, done_tog, init_run;
  logic [CNT_W-1:0] init_cnt;

  // classify the rising half of ca; reserved codes are inert
  function automatic cmd_type decode(input logic csn, input logic [CA_W-1:0] c);
    if (csn || c[2:0] == OP_NOP) decode = CMD_NOP;
    else if (c[1:0] == OP_ACT) decode = CMD_ACT;
    else if (c[2:0] == OP_WR) decode = CMD_WR;
    else if (c[2:0] == OP_RD) decode = CMD_RD;
    else if (c[3:0] == OP_MRW) decode = CMD_MRW;
    else if (c[3:0] == OP_MRR) decode = CMD_MRR;
    else if (c[3:0] == OP_REF_PB) decode = CMD_REF_PB;
    else if (c[3:0] == OP_REF_AB) decode = CMD_REF_AB;
    else if (c[3:0] == OP_PRE) decode = CMD_PRE;
    else if (c[3:0] == OP_BST) decode = CMD_BST;
    else decode = CMD_RSVD;
  endfunction

  // reset into the link domain; ck must run while rst is held
  sync_3ff u_rst_sync (
    .clk(ck),
    .rst(1'b0),
    .din(rst),
    .dout(rst_ck)
  );

  // pins sampled at the rising edge; cke history gives edge n-1 and n
  always_ff @(posedge ck) begin
    if (rst_ck) begin
      cke_cur <= 1'b0;
      cke_prev <= 1'b0;
      csn_q <= 1'b1;
      ca_q <= '0;
    end else begin
      cke_cur <= cke;
      cke_prev <= cke_cur;
      csn_q <= cs_n;
      ca_q <= ca;
    end
  end

  // falling half carries auto precharge and the upper mode address bits
  always_ff @(negedge ck) begin
    if (rst_ck) begin
      ca_f <= '0;
    end else begin
      ca_f <= ca[CA_F_W-1:0];
    end
  end

  // decode of the registered command; state moves one edge later
  assign cmd = decode(csn_q, ca_q);
  assign both_high = cke_prev & cke_cur;
  assign cke_fall = cke_prev & ~cke_cur;
  assign exit_nop = ~cke_prev & cke_cur & csn_q;
  assign ba = ca_q[CA_BA_LO +: BANK_W];
  assign ma = {ca_f, ca_q[CA_MA_LO +: (CA_W - CA_MA_LO)]};
  assign is_reset = cmd == CMD_MRW && ma == RESET_MA;
  assign all_idle = &bank_idle;
  assign dev_cmd = both_high && exit_cnt == '0; // RULE_11 RULE_06
  assign cmd_open = dev_cmd && dev_state == DEV_NORMAL; // RULE_11
  assign start_init = dev_cmd && is_reset &&
    (dev_state == DEV_POWER_ON || (dev_state == DEV_NORMAL && all_idle)); // RULE_13 RULE_19
  assign init_exp = done_ck == rst_tog;

  // per-bank strobes and state machines
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    assign hit = ba == BANK_W'(b);
    assign act_v[b] = cmd_open && cmd == CMD_ACT && hit;
    assign rd_v[b] = cmd_open && cmd == CMD_RD && hit;
    assign wr_v[b] = cmd_open && cmd == CMD_WR && hit;
    assign pre_v[b] = cmd_open && cmd == CMD_PRE && (ca_q[CA_AB] || hit); // RULE_14
    assign ref_v[b] = cmd_open && cmd == CMD_REF_PB && hit; // RULE_12
    assign bst_v[b] = cmd_open && cmd == CMD_BST && last_bank == BANK_W'(b); // RULE_24
    assign mrr_v[b] = cmd_open && cmd == CMD_MRR && !all_idle; // RULE_15
    bank_fsm #(
      .TRP(TRP),
      .TRCD(TRCD),
      .TRFC(TRFCPB),
      .TMRR(TMRR)
    ) u_bank (
      .clk(ck),
      .rst(rst_ck),
      .act(act_v[b]),
      .rd(rd_v[b]),
      .wr(wr_v[b]),
      .pre(pre_v[b]),
      .bst(bst_v[b]),
      .ref_cmd(ref_v[b]),
      .mrr(mrr_v[b]),
      .ap(ca_f[CA_AP]),
      .state(bank_state[b]),
      .idle(bank_idle[b])
    );
  end

  // bank of the latest burst, target of a later terminate
  always_ff @(posedge ck) begin
    if (rst_ck) begin
      last_bank <= '0;
    end else if (cmd_open && (cmd == CMD_RD || cmd == CMD_WR)) begin
      last_bank <= ba; // RULE_24
    end
  end

  // device power state; low-power states react to nothing but an exit nop
  always_comb begin
    next_dev = dev_state;
    next_dtmr = (dtmr == '0) ? dtmr : dtmr - 1'b1;
    next_exit = (exit_cnt == '0) ? exit_cnt : exit_cnt - 1'b1;
    case (dev_state)
      DEV_POWER_ON: begin
        if (start_init) next_dev = DEV_RESETTING; // RULE_19
      end
      DEV_RESETTING: begin
        if (cke_fall && csn_q) begin
          next_dev = DEV_RES_PD; // RULE_08
        end else if (dev_cmd && cmd == CMD_MRR) begin
          next_dev = DEV_RES_MRR; // RULE_19
          next_dtmr = TMR_W'(TMRR - 1);
        end else if (init_exp) begin
          next_dev = DEV_NORMAL;
        end
      end
      DEV_NORMAL: begin
        if (cke_fall && csn_q) begin
          next_dev = all_idle ? DEV_IDLE_PD : DEV_ACT_PD; // RULE_08
        end else if (cke_fall && all_idle && ca_q[2:0] == OP_SREF) begin
          next_dev = DEV_SELF_REF; // RULE_09
        end else if (cke_fall && all_idle && ca_q[2:0] == OP_DPD) begin
          next_dev = DEV_DEEP_PD; // RULE_09
        end else if (start_init) begin
          next_dev = DEV_RESETTING; // RULE_13
        end else if (cmd_open && all_idle && cmd == CMD_MRW) begin
          next_dev = DEV_MR_WRITING; // RULE_13
          next_dtmr = TMR_W'(TMRW - 1);
        end else if (cmd_open && all_idle && cmd == CMD_MRR) begin
          next_dev = DEV_IDLE_MRR; // RULE_13
          next_dtmr = TMR_W'(TMRR - 1);
        end else if (cmd_open && all_idle && cmd == CMD_REF_AB) begin
          next_dev = DEV_REF_ALL; // RULE_12
          next_dtmr = TMR_W'(TRFCAB - 1);
        end
      end
      DEV_MR_WRITING, DEV_IDLE_MRR, DEV_REF_ALL: begin
        if (dtmr == '0) next_dev = DEV_NORMAL;
      end
      DEV_RES_MRR: begin
        if (dtmr == '0) next_dev = DEV_RESETTING;
      end
      DEV_ACT_PD, DEV_IDLE_PD: begin
        if (exit_nop) begin
          next_dev = DEV_NORMAL; // RULE_02 RULE_01
          next_exit = TMR_W'(TXP); // RULE_07
        end
      end
      DEV_RES_PD: begin
        if (exit_nop) begin
          next_dev = init_exp ? DEV_NORMAL : DEV_RESETTING; // RULE_03 RULE_01
          next_exit = TMR_W'(TXP);
        end
      end
      DEV_SELF_REF: begin
        if (exit_nop) begin
          next_dev = DEV_NORMAL; // RULE_05 RULE_01
          next_exit = TMR_W'(TXSR);
        end
      end
      DEV_DEEP_PD: begin
        if (exit_nop) next_dev = DEV_POWER_ON; // RULE_04 RULE_01
      end
      default: next_dev = DEV_POWER_ON;
    endcase
  end

  // RULE_25
  always_ff @(posedge ck) begin
    if (rst_ck) begin
      dev_state <= DEV_POWER_ON;
      dtmr <= '0;
      exit_cnt <= '0;
    end else begin
      dev_state <= next_dev;
      dtmr <= next_dtmr;
      exit_cnt <= next_exit;
    end
  end

  // a reset command in power on, or in normal with all banks idle, starts a new init epoch, marked by a toggle
  always_ff @(posedge ck) begin
    if (rst_ck) begin
      rst_tog <= 1'b0;
    end else if (start_init) begin
      rst_tog <= ~rst_tog;
    end
  end

  // epoch toggle into mclk, finished epoch back into ck
  sync_3ff u_tog_sync (
    .clk(mclk),
    .rst(rst),
    .din(rst_tog),
    .dout(tog_m)
  );
  sync_3ff u_done_sync (
    .clk(ck),
    .rst(rst_ck),
    .din(done_tog),
    .dout(done_ck)
  );

  // init interval on mclk; a new epoch restarts the count
  always_ff @(posedge mclk) begin
    if (rst) begin
      tog_seen <= 1'b0;
      done_tog <= 1'b0;
      init_run <= 1'b0;
      init_cnt <= '0;
    end else if (tog_m != tog_seen) begin
      tog_seen <= tog_m;
      init_run <= 1'b1;
      init_cnt <= CNT_W'(INIT5_CYCLES - 1);
    end else if (init_run && init_cnt == '0) begin
      init_run <= 1'b0;
      done_tog <= tog_seen;
    end else if (init_run) begin
      init_cnt <= init_cnt - 1'b1;
    end
  end

  // registered status; a new epoch clears it, so odd and even epochs read alike
  always_ff @(posedge mclk) begin
    if (rst) begin
      init_done <= 1'b0;
    end else begin
      init_done <= tog_m == tog_seen && (init_done || (init_run && init_cnt == '0));
    end
  end

  lp_hold_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_01
    dev_state inside {DEV_ACT_PD, DEV_IDLE_PD, DEV_RES_PD, DEV_SELF_REF, DEV_DEEP_PD}
    && !cke_prev && !cke_cur |=> dev_state == $past(dev_state))
    else $error("low-power state left while cke stayed low");
  pd_exit_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_02
    dev_state == DEV_ACT_PD && exit_nop |=> dev_state == DEV_NORMAL && exit_cnt == TMR_W'(TXP))
    else $error("active power down exit wrong");
  res_exit_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_03
    dev_state == DEV_RES_PD && exit_nop && !init_exp |=> dev_state == DEV_RESETTING)
    else $error("resetting power down exit did not return to resetting");
  dpd_exit_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_04
    dev_state == DEV_DEEP_PD && exit_nop |=> dev_state == DEV_POWER_ON)
    else $error("deep power down exit did not reach power on");
  sref_exit_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_05
    dev_state == DEV_SELF_REF && exit_nop |=> dev_state == DEV_NORMAL ##1 !cmd_open)
    else $error("self refresh exit did not hold off commands");
  pd_entry_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_08
    dev_state == DEV_NORMAL && cke_fall && csn_q && !all_idle |=> dev_state == DEV_ACT_PD)
    else $error("active power down not entered");
  sref_entry_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_09
    dev_state == DEV_NORMAL && cke_fall && !csn_q && ca_q[2:0] == OP_SREF && !all_idle
    |=> dev_state == DEV_NORMAL)
    else $error("self refresh entered with a bank busy");
  cmd_gate_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_11
    (exit_cnt != '0 || !both_high) |-> (act_v | rd_v | wr_v | pre_v | ref_v | bst_v) == '0)
    else $error("bank command passed while gated");
  bst_pick_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_24
    cmd_open && cmd == CMD_BST |-> $onehot(bst_v) && bst_v[last_bank])
    else $error("terminate not routed to latest burst bank");
  mrw_go_a: assert property (@(posedge ck) disable iff (rst_ck) // RULE_13
    cmd_open && all_idle && cmd == CMD_MRW && !is_reset
    |=> dev_state == DEV_MR_WRITING [*5] ##1 dev_state == DEV_NORMAL)
    else $error("mode write interval wrong");
endmodule
`default_nettype wire

// >>> tb/ctrl_model.sv
// ctrl_model: controller side of the link, makes ck and drives cke, cs_n, ca
// assumes the bench calls one task at a time, never two in one time step
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
  output logic ck, // link clock, 30 ns
  output logic cke, // clock enable
  output logic cs_n, // chip select, active low
  output logic [lp_state_pkg::CA_W-1:0] ca // command/address
);
  import lp_state_pkg::*;
  // clock runs free, so it toggles through every exit interval
  initial begin
    ck = 1'h0;
    cke = 1'h1;
    cs_n = 1'h1;
    ca = 10'h000;
    forever #15 ck = ~ck;
  end
  // one command at rise n, falling half after it, then a nop with cke held
  task cmd(input logic k, input logic s, input logic [CA_W-1:0] r, input logic [1:0] f);
    @(negedge ck);
    cke <= k;
    cs_n <= s;
    ca <= r;
    @(posedge ck);
    ca[1:0] <= f;
    @(negedge ck);
    cs_n <= 1'h1;
    ca <= ~ca; // released bus shows no stale value
    @(posedge ck);
    #1;
  endtask
  // cke edge with cs_n high: power down entry or exit, ca carries nothing
  task cke_to(input logic k);
    cmd(k, 1'h1, 10'h000, 2'h0);
  endtask
  // only nops, e.g. while an exit or bank interval runs out
  task nop(input int n);
    repeat (n) begin
      @(negedge ck);
      cs_n <= 1'h1;
      ca <= ~ca;
      @(posedge ck);
    end
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the power and bank state tracker
// assumes ctrl_model drives the link; init interval and tXSR shortened
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lp_state_pkg::*;
  localparam logic [9:0] RST_C = {6'h3F, OP_MRW};
  localparam logic [9:0] ACT2 = {3'h2, 5'h00, OP_ACT};
  localparam logic [9:0] RD2 = {3'h2, 4'h0, OP_RD};
  localparam logic [9:0] WR2 = {3'h2, 4'h0, OP_WR};
  localparam logic [9:0] PRE2 = {3'h2, 3'h0, OP_PRE};
  localparam logic [9:0] BST = {6'h00, OP_BST};
  localparam logic [9:0] SREF = {7'h00, OP_SREF};
  localparam logic [9:0] DPD = {7'h00, OP_DPD};
  localparam logic [9:0] PREA = {3'h0, 3'h1, OP_PRE};
  localparam logic [9:0] MRR_C = {6'h00, OP_MRR};
  logic mclk, rst, ck, cke, cs_n, cmd_open, init_done;
  logic [CA_W-1:0] ca;
  dev_type dev_state;
  bank_type bank_state [NUM_BANKS];
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  ctrl_model ctrl_model_inst (.ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca));
  sdram_bank_power_state_tracker #(.INIT5_CYCLES(20), .TXSR(8)) sdram_bank_power_state_tracker_inst (
    .mclk(mclk), .rst(rst), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca), .dev_state(dev_state),
    .bank_state(bank_state), .cmd_open(cmd_open), .init_done(init_done));
  task fail(input string m);
    $display("[FAIL] %0t %s", $time, m);
    bad_count++;
  endtask
  task chk_dev(input dev_type e);
    comparisons++;
    if (dev_state !== e) fail("device state");
  endtask
  task chk_bank(input int i, input bank_type e);
    comparisons++;
    if (bank_state[i] !== e) fail("bank state");
  endtask
  task chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) fail("flag level");
  endtask
  task final_report;
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reset command, resetting power down left before init is over
  task t_reset;
    chk_dev(DEV_POWER_ON);
    chk_bit(init_done, 1'h0);
    ctrl_model_inst.cmd(1'h1, 1'h0, RST_C, 2'h0);
    chk_dev(DEV_RESETTING);
    ctrl_model_inst.cke_to(1'h0);
    chk_dev(DEV_RES_PD);
    ctrl_model_inst.cke_to(1'h1);
    chk_dev(DEV_RESETTING);
    for (int k = 0; k < 200 && init_done !== 1'h1; k++) @(posedge mclk);
    chk_bit(init_done, 1'h1);
    ctrl_model_inst.nop(8);
    chk_dev(DEV_NORMAL);
  endtask
  // activate, then read/write/terminate chain on bank 2
  task t_bank;
    ctrl_model_inst.cmd(1'h1, 1'h0, ACT2, 2'h0);
    chk_bank(2, B_ACTIVATING);
    ctrl_model_inst.nop(2);
    chk_bank(2, B_ACTIVATING);
    ctrl_model_inst.nop(1);
    chk_bank(2, B_ACTIVE);
    ctrl_model_inst.cmd(1'h1, 1'h0, RD2, 2'h0);
    chk_bank(2, B_READING);
    ctrl_model_inst.cmd(1'h1, 1'h0, WR2, 2'h0);
    chk_bank(2, B_WRITING);
    ctrl_model_inst.cmd(1'h1, 1'h0, RD2, 2'h0);
    chk_bank(2, B_READING);
    ctrl_model_inst.cmd(1'h1, 1'h0, BST, 2'h0);
    chk_bank(2, B_ACTIVE);
    chk_bank(0, B_IDLE);
  endtask
  // power down with a bank open, ignored command, exit, precharge, idle pd
  task t_pd;
    ctrl_model_inst.cke_to(1'h0);
    chk_dev(DEV_ACT_PD);
    ctrl_model_inst.cmd(1'h0, 1'h0, RD2, 2'h0);
    chk_dev(DEV_ACT_PD);
    chk_bank(2, B_ACTIVE);
    ctrl_model_inst.cke_to(1'h1);
    chk_dev(DEV_NORMAL);
    chk_bit(cmd_open, 1'h0);
    ctrl_model_inst.nop(3);
    chk_bit(cmd_open, 1'h1);
    ctrl_model_inst.cmd(1'h1, 1'h0, PRE2, 2'h0);
    chk_bank(2, B_PRECHARGING);
    ctrl_model_inst.nop(2);
    chk_bank(2, B_PRECHARGING);
    ctrl_model_inst.nop(1);
    chk_bank(2, B_IDLE);
    ctrl_model_inst.cke_to(1'h0);
    chk_dev(DEV_IDLE_PD);
    ctrl_model_inst.cke_to(1'h1);
    chk_dev(DEV_NORMAL);
    ctrl_model_inst.nop(3);
  endtask
  // falling half in use: auto precharge, high mode address bits; then mode read, precharge all
  task t_mode;
    ctrl_model_inst.cmd(1'h1, 1'h0, ACT2, 2'h0);
    ctrl_model_inst.nop(3);
    chk_bank(2, B_ACTIVE);
    ctrl_model_inst.cmd(1'h1, 1'h0, RD2, 2'h1);
    chk_bank(2, B_RD_AP);
    ctrl_model_inst.nop(3);
    chk_bank(2, B_IDLE);
    ctrl_model_inst.cmd(1'h1, 1'h0, RST_C, 2'h1);
    chk_dev(DEV_MR_WRITING);
    ctrl_model_inst.nop(5);
    chk_dev(DEV_NORMAL);
    ctrl_model_inst.cmd(1'h1, 1'h0, MRR_C, 2'h0);
    chk_dev(DEV_IDLE_MRR);
    ctrl_model_inst.nop(2);
    chk_dev(DEV_NORMAL);
    ctrl_model_inst.cmd(1'h1, 1'h0, PREA, 2'h0);
    chk_bank(5, B_PRECHARGING);
    ctrl_model_inst.nop(3);
    chk_bank(5, B_IDLE);
  endtask
  // self refresh and deep power down entry and exit
  task t_lp;
    ctrl_model_inst.cmd(1'h0, 1'h0, SREF, 2'h0);
    chk_dev(DEV_SELF_REF);
    ctrl_model_inst.cmd(1'h0, 1'h0, ACT2, 2'h0);
    chk_dev(DEV_SELF_REF);
    ctrl_model_inst.cke_to(1'h1);
    chk_dev(DEV_NORMAL);
    ctrl_model_inst.nop(10);
    ctrl_model_inst.cmd(1'h0, 1'h0, DPD, 2'h0);
    chk_dev(DEV_DEEP_PD);
    ctrl_model_inst.cke_to(1'h1);
    chk_dev(DEV_POWER_ON);
  endtask
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // reset is held long enough to pass the link-side synchroniser
  initial begin
    rst = 1'h1;
    repeat (10) @(negedge mclk);
    rst <= 1'h0;
    ctrl_model_inst.nop(8);
    t_reset;
    t_bank;
    t_pd;
    t_mode;
    t_lp;
    final_report;
  end
  // hang guard: the whole run needs well under this many mclk cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      final_report;
    end
  end
endmodule
`default_nettype wire
